// *** rtl/epv_regs.svh ***
// Vector addresses, source codes and reset values of the exception unit
`ifndef EPV_REGS_SVH
`define EPV_REGS_SVH

// Non-maskable vectors, highest first
`define EPV_VEC_RESET  16'hFFFE
`define EPV_VEC_CLKMON 16'hFFFC
`define EPV_VEC_WDOG   16'hFFFA
`define EPV_VEC_TRAP   16'hFFF8
`define EPV_VEC_SWI    16'hFFF6
`define EPV_VEC_NMI    16'hFFF4

// High byte shared by all maskable vectors
`define EPV_VEC_PAGE   8'hFF

// Maskable source codes, equal to the vector low byte, and the step between timer codes
`define EPV_CODE_EXT   8'hF2
`define EPV_CODE_TICK  8'hF0
`define EPV_CODE_TMR0  8'hEE
`define EPV_CODE_TSTEP 8'h02
`define EPV_CODE_TWRAP 8'hDE
`define EPV_CODE_PAOV  8'hDC
`define EPV_CODE_PAED  8'hDA
`define EPV_CODE_SSER  8'hD8
`define EPV_CODE_ASER  8'hD6
`define EPV_CODE_ADC   8'hD2
`define EPV_CODE_LINK  8'hD0
`define EPV_CODE_DCNT  8'hCC
`define EPV_CODE_PBOV  8'hCA

// Source count and slot layout
`define EPV_NSRC       19
`define EPV_IDX_W      5
`define EPV_NTMR       8
`define EPV_IDX_EXT    0
`define EPV_IDX_TMR0   2
`define EPV_IDX_TICK   1
`define EPV_IDX_TWRAP  10
`define EPV_IDX_PAOV   11
`define EPV_IDX_PAED   12
`define EPV_IDX_SSER   13
`define EPV_IDX_ASER   14
`define EPV_IDX_ADC    15
`define EPV_IDX_LINK   16
`define EPV_IDX_DCNT   17
`define EPV_IDX_PBOV   18

// Reset values
`define EPV_PRIO_RST   8'hF2
`define EPV_CCR_I_RST  1'b1
`define EPV_CCR_X_RST  1'b1
`define EPV_PIN_IDLE   2'h3

`endif

// *** rtl/epv_pkg.sv ***
// Types shared by the exception unit
package epv_pkg;

    typedef enum logic [1:0] {
        EPV_IDLE,
        EPV_RD_HI,
        EPV_RD_LO,
        EPV_WT_LO
    } epv_state_t;

    typedef logic [7:0] epv_code_t;

endpackage : epv_pkg

// *** rtl/epv_exception_unit.sv ***
// Exception prioritisation and vector fetch for the core sequencer
//
// Function
// RULE1: Every exception vector is 16 bits in the top 128 bytes.
// RULE2: Six highest vectors serve resets and non-maskables; lower ones maskable.
// RULE3: Software fills every maskable vector with a valid routine address.
// RULE4: Of several pending requests exactly one is serviced, by fixed priority.
// RULE5: Order: reset, clock monitor, watchdog, trap, software interrupt, pin.
// RULE6: Non-maskable pin is accepted only while its mask bit is 0.
// RULE7: Clock monitor reset at FFFC, gated by its enables; watchdog at FFFA.
// RULE8: Trap at FFF8, software interrupt at FFF6, non-maskable pin at FFF4.
// RULE9: Maskable requests are recognised only while the global mask is clear.
// RULE10: Global mask resets to 1 and is writable at any time.
// RULE11: Default maskable order descends by vector; code equals vector low byte.
// RULE12: Elevation select moves one source to top, others keep their order.
// RULE13: Elevated source still obeys global mask and its local enable.
// RULE14: Elevation never changes the vector supplied for a source.
// RULE15: Elevation writes count only while the global mask is set.
// RULE16: Timer wrap FFDE, pulse wrap FFDC, pulse edge FFDA, each enabled.
// RULE17: Sync serial FFD8, converter FFD2, data link FFD0, async serial FFD6.
// RULE18: Down counter FFCC, pulse B wrap FFCA, each locally enabled.
// RULE19: Vectors FF80 to FFC1 are reserved; no source requests them.
// RULE20: Vector is fetched as two bytes, high byte at the lower address.
// RULE21: Edge select 1 gives falling edges, 0 gives low level on the pin.
// RULE22: Edge mode latches the pin edge, cleared when it is serviced.
// RULE23: Service with no active source takes the trap vector.
// RULE24: Maskable request needs both its pending flag and local enable.
// RULE25: Elevation select resets to leave the default order in force.
`timescale 1ns/1ns
`include "epv_regs.svh"

module epv_exception_unit
    import epv_pkg::*;
(
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_srst,
    // Non-maskable requests
    input  wire logic                    i_por_req,
    input  wire logic                    i_clkmon_fail,
    input  wire logic                    i_clock_monitor_enable,
    input  wire logic                    i_forced_clock_monitor_enable,
    input  wire logic                    i_wdog_fail,
    input  wire logic                    i_trap_req,
    input  wire logic                    i_swi_req,
    input  wire logic                    i_nonmaskable_request_pin_n,
    // Condition code mask bits
    input  wire logic                    i_ccr_wr,
    input  wire logic                    i_ccr_i,
    input  wire logic                    i_ccr_x,
    output logic                         o_ccr_i,
    output logic                         o_ccr_x,
    // Priority elevation select
    input  wire logic                    i_prio_wr,
    input  wire logic [7:0]              i_prio_data,
    output logic [7:0]                   o_prio_sel,
    // External request pin
    input  wire logic                    i_ext_req_pin_n,
    input  wire logic                    i_external_request_enable,
    input  wire logic                    i_edge_only_select,
    // Peripheral flags and enables, slot 1 upward
    input  wire logic [`EPV_NSRC-2:0]    i_pend,
    input  wire logic [`EPV_NSRC-2:0]    i_en,
    // Core sequencer
    input  wire logic                    i_svc_start,
    output logic                         o_pending,
    output logic [15:0]                  o_vector,
    output logic                         o_src_ack,
    output logic [`EPV_IDX_W-1:0]        o_src_idx,
    // Vector fetch
    output logic                         o_mem_rd,
    output logic [15:0]                  o_mem_addr,
    input  wire logic [7:0]              i_mem_data,
    output logic                         o_done,
    output logic [15:0]                  o_handler
);

    ////////////////////////////////////////////////////////////////////////////
    // Source code table
    localparam int NSRC = `EPV_NSRC;
    localparam int IW   = `EPV_IDX_W;

    epv_code_t code_tab [NSRC];

    // Codes stay below F4 and above C1, clear of the reserved block
    assign code_tab[`EPV_IDX_EXT] = `EPV_CODE_EXT;   // RULE11
    assign code_tab[`EPV_IDX_TICK]  = `EPV_CODE_TICK;
    assign code_tab[`EPV_IDX_TWRAP] = `EPV_CODE_TWRAP; // RULE16
    assign code_tab[`EPV_IDX_PAOV]  = `EPV_CODE_PAOV;  // RULE16
    assign code_tab[`EPV_IDX_PAED]  = `EPV_CODE_PAED;  // RULE16
    assign code_tab[`EPV_IDX_SSER]  = `EPV_CODE_SSER;  // RULE17
    assign code_tab[`EPV_IDX_ASER]  = `EPV_CODE_ASER;  // RULE17
    assign code_tab[`EPV_IDX_ADC]   = `EPV_CODE_ADC;   // RULE17
    assign code_tab[`EPV_IDX_LINK]  = `EPV_CODE_LINK;  // RULE17
    assign code_tab[`EPV_IDX_DCNT]  = `EPV_CODE_DCNT;  // RULE18
    assign code_tab[`EPV_IDX_PBOV]  = `EPV_CODE_PBOV;  // RULE18 RULE19

    genvar t;
    generate
        for (t = 0; t < `EPV_NTMR; t++) begin : g_tmr
            assign code_tab[`EPV_IDX_TMR0 + t] =
                8'(`EPV_CODE_TMR0 - t * `EPV_CODE_TSTEP); // RULE11
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic            ccr_i_q;
    logic            ccr_x_q;
    epv_code_t       prio_q;
    logic [1:0]      nmi_sync_q;
    logic [1:0]      ext_sync_q;
    logic            ext_prev_q;
    logic            ext_lat_q;
    logic            ext_lat_d;
    epv_state_t      state_q;
    logic [15:0]     vec_q;
    logic [7:0]      hi_q;
    logic            pending_q;
    logic            src_ack_q;
    logic [IW-1:0]   src_idx_q;
    logic            mem_rd_q;
    logic [15:0]     mem_addr_q;
    logic            done_q;
    logic [15:0]     handler_q;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            nmi_sync_q <= `EPV_PIN_IDLE;
            ext_sync_q <= `EPV_PIN_IDLE;
            ext_prev_q <= 1'b1;
        end else begin
            nmi_sync_q <= {nmi_sync_q[0], i_nonmaskable_request_pin_n};
            ext_sync_q <= {ext_sync_q[0], i_ext_req_pin_n};
            ext_prev_q <= ext_sync_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External request, level or latched edge
    logic ext_fall;
    logic ext_clr;
    logic ext_req;

    assign ext_fall  = ext_prev_q & ~ext_sync_q[1];
    // Set wins over a service clear in the same cycle
    assign ext_lat_d = i_edge_only_select
                     & (ext_fall | (ext_lat_q & ~ext_clr)); // RULE22
    assign ext_req   = i_external_request_enable
                     & (i_edge_only_select ? ext_lat_q
                                           : ~ext_sync_q[1]); // RULE21

    ////////////////////////////////////////////////////////////////////////////
    // Maskable selection
    logic [NSRC-1:0] req;
    logic [NSRC-1:0] mreq;
    logic [NSRC-1:0] hit;
    logic [NSRC-1:0] dgrant;
    logic [NSRC-1:0] grant;
    logic [NSRC:0]   taken;
    epv_code_t       code_or [NSRC+1];
    logic [IW-1:0]   idx_or [NSRC+1];
    logic            any_hit;
    logic            win_any;

    assign req      = {i_pend & i_en, ext_req};              // RULE24
    assign mreq     = req & {NSRC{~ccr_i_q}};                // RULE9 RULE13
    assign any_hit  = |hit;
    assign win_any  = |mreq;
    assign grant    = any_hit ? hit : dgrant;                // RULE12
    assign taken[0] = 1'b0;
    assign code_or[0] = '0;
    assign idx_or[0]  = '0;

    genvar k;
    generate
        for (k = 0; k < NSRC; k++) begin : g_src
            assign hit[k]     = mreq[k] & (code_tab[k] == prio_q); // RULE12
            assign dgrant[k]  = mreq[k] & ~taken[k];               // RULE11
            assign taken[k+1] = taken[k] | mreq[k];
            // Vector follows the source, not its rank
            assign code_or[k+1] = code_or[k]
                                | ({8{grant[k]}} & code_tab[k]);   // RULE14
            assign idx_or[k+1]  = idx_or[k]
                                | ({IW{grant[k]}} & IW'(k));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Non-maskable selection and final vector
    logic        cm_req;
    logic        nmi_req;
    logic        nm_any;
    logic [15:0] sel_vec;
    logic        sel_mask;
    logic        take;

    assign cm_req  = i_clkmon_fail & (i_clock_monitor_enable
                   | i_forced_clock_monitor_enable);        // RULE7
    assign nmi_req = ~nmi_sync_q[1] & ~ccr_x_q;             // RULE6
    assign nm_any  = i_por_req | cm_req | i_wdog_fail
                   | i_trap_req | i_swi_req | nmi_req;

    // One winner, fixed order
    assign sel_vec = i_por_req   ? `EPV_VEC_RESET  :        // RULE4 RULE5
                     cm_req      ? `EPV_VEC_CLKMON :        // RULE7
                     i_wdog_fail ? `EPV_VEC_WDOG   :        // RULE7
                     i_trap_req  ? `EPV_VEC_TRAP   :        // RULE8
                     i_swi_req   ? `EPV_VEC_SWI    :        // RULE8
                     nmi_req     ? `EPV_VEC_NMI    :        // RULE8 RULE2
                     win_any     ? {`EPV_VEC_PAGE, code_or[NSRC]} : // RULE1 RULE2
                                   `EPV_VEC_TRAP;           // RULE23

    assign sel_mask = ~nm_any & win_any;
    assign take     = (state_q == EPV_IDLE) & i_svc_start;
    assign ext_clr  = take & sel_mask
                    & (idx_or[NSRC] == IW'(`EPV_IDX_EXT));  // RULE22

    ////////////////////////////////////////////////////////////////////////////
    // Mask bits and elevation select
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ccr_i_q <= `EPV_CCR_I_RST;                      // RULE10
            ccr_x_q <= `EPV_CCR_X_RST;
            prio_q  <= `EPV_PRIO_RST;                       // RULE25
        end else begin
            if (i_ccr_wr) begin
                ccr_i_q <= i_ccr_i;                         // RULE10
                ccr_x_q <= i_ccr_x;
            end
            // Old mask value decides when both are written together
            if (i_prio_wr && ccr_i_q) begin
                prio_q <= i_prio_data;                      // RULE15
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Service sequence and two-byte fetch
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_q    <= EPV_IDLE;
            vec_q      <= '0;
            hi_q       <= '0;
            ext_lat_q  <= 1'b0;
            pending_q  <= 1'b0;
            src_ack_q  <= 1'b0;
            src_idx_q  <= '0;
            mem_rd_q   <= 1'b0;
            mem_addr_q <= '0;
            done_q     <= 1'b0;
            handler_q  <= '0;
        end else begin
            ext_lat_q <= ext_lat_d;
            pending_q <= nm_any | win_any;
            src_ack_q <= take & sel_mask;
            done_q    <= 1'b0;
            case (state_q)
                EPV_IDLE: begin
                    if (i_svc_start) begin
                        vec_q      <= sel_vec;
                        src_idx_q  <= idx_or[NSRC];
                        mem_addr_q <= sel_vec;              // RULE20
                        mem_rd_q   <= 1'b1;
                        state_q    <= EPV_RD_HI;
                    end
                end
                EPV_RD_HI: begin
                    mem_addr_q <= 16'(vec_q + 16'h0001);    // RULE20
                    state_q    <= EPV_RD_LO;
                end
                EPV_RD_LO: begin
                    hi_q     <= i_mem_data;                 // RULE20
                    mem_rd_q <= 1'b0;
                    state_q  <= EPV_WT_LO;
                end
                EPV_WT_LO: begin
                    handler_q <= {hi_q, i_mem_data};        // RULE20
                    done_q    <= 1'b1;
                    state_q   <= EPV_IDLE;
                end
                default: begin
                    mem_rd_q <= 1'b0;
                    state_q  <= EPV_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_ccr_i    = ccr_i_q;
    assign o_ccr_x    = ccr_x_q;
    assign o_prio_sel = prio_q;
    assign o_pending  = pending_q;
    assign o_vector   = vec_q;
    assign o_src_ack  = src_ack_q;
    assign o_src_idx  = src_idx_q;
    assign o_mem_rd   = mem_rd_q;
    assign o_mem_addr = mem_addr_q;
    assign o_done     = done_q;
    assign o_handler  = handler_q;

endmodule : epv_exception_unit

// *** verif/epv_mem_model.sv ***
// Vector table memory seen by the fetch port
`timescale 1ns/1ns
module epv_mem_model (
    // Fetch port
    input  wire logic        i_clk,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_addr,
    output logic      [7:0]  o_data
);
    initial o_data = 8'h00;
    ////////////////////////////////////////////////////////////////////////////
    // Every slot holds a routine address, one-cycle latency; idle bus toggles
    always @(posedge i_clk) begin
        if (i_rd) begin
            o_data <= i_addr[7:0] ^ 8'hA5;
        end else begin
            o_data <= ~o_data;
        end
    end
endmodule : epv_mem_model

// *** verif/epv_exception_unit_props.sv ***
// Port checks for the exception unit
`timescale 1ns/1ns
module epv_props (
    // Clock and requests
    input wire logic        i_clk,
    input wire logic        i_srst,
    input wire logic        i_por_req,
    input wire logic        i_clkmon_fail,
    input wire logic        i_clock_monitor_enable,
    input wire logic        i_forced_clock_monitor_enable,
    input wire logic        i_wdog_fail,
    input wire logic        i_trap_req,
    input wire logic        i_swi_req,
    // Masks and elevation
    input wire logic        i_ccr_wr,
    input wire logic        i_ccr_i,
    input wire logic        i_ccr_x,
    input wire logic        o_ccr_i,
    input wire logic        o_ccr_x,
    input wire logic        i_prio_wr,
    input wire logic [7:0]  i_prio_data,
    input wire logic [7:0]  o_prio_sel,
    // Service and fetch
    input wire logic        i_svc_start,
    input wire logic [15:0] o_vector,
    input wire logic        o_src_ack,
    input wire logic        o_mem_rd,
    input wire logic [15:0] o_mem_addr,
    input wire logic [7:0]  i_mem_data,
    input wire logic        o_done,
    input wire logic [15:0] o_handler
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    logic rd_q;
    always_ff @(posedge i_clk) rd_q <= o_mem_rd;
    // Take only seen while idle; a start inside a fetch is refused
    wire take_w = i_svc_start && !o_mem_rd && !rd_q;
    wire cm_w = i_clkmon_fail && (i_clock_monitor_enable || i_forced_clock_monitor_enable);
    wire nm_w = i_por_req || cm_w || i_wdog_fail || i_trap_req || i_swi_req;
    sequence s_hi; o_mem_rd && o_mem_addr == o_vector; endsequence
    sequence s_lo; o_mem_rd && o_mem_addr == o_vector + 16'h0001; endsequence
    sequence s_end; !o_mem_rd ##1 o_done; endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_fetch_order: assert property ($rose(o_mem_rd) |-> s_hi ##1 s_lo ##1 s_end)
        else $error("vector fetch steps out of order");
    a_handler_bytes: assert property (o_done |->
        o_handler == {$past(i_mem_data, 2), $past(i_mem_data)}) else $error("handler bytes wrong");
    a_vec_range: assert property ($rose(o_mem_rd) |-> o_vector[15:7] == 9'h1FF
        && !o_vector[0] && !(o_vector >= 16'hFF80 && o_vector <= 16'hFFC1))
        else $error("vector outside table");
    a_reset_first: assert property (take_w && i_por_req |=> o_vector == 16'hFFFE)
        else $error("reset not first");
    a_wdog_vec: assert property (take_w && !i_por_req && !cm_w && i_wdog_fail
        |=> o_vector == 16'hFFFA) else $error("watchdog vector wrong");
    a_trap_vec: assert property (take_w && !i_por_req && !cm_w && !i_wdog_fail
        && i_trap_req |=> o_vector == 16'hFFF8) else $error("trap vector wrong");
    a_masked_idle: assert property (take_w && !nm_w && o_ccr_i && o_ccr_x
        |=> o_vector == 16'hFFF8 && !o_src_ack) else $error("masked take not trap");
    a_ack_kind: assert property (o_src_ack |-> !$past(o_ccr_i) && o_vector < 16'hFFF4)
        else $error("maskable ack while masked");
    a_prio_ignore: assert property (i_prio_wr && !o_ccr_i |=> $stable(o_prio_sel))
        else $error("elevation written while unmasked");
    a_prio_load: assert property (i_prio_wr && o_ccr_i |=> o_prio_sel == $past(i_prio_data))
        else $error("elevation write lost");
    a_ccr_load: assert property (i_ccr_wr |=> o_ccr_i == $past(i_ccr_i)
        && o_ccr_x == $past(i_ccr_x)) else $error("mask write lost");
endmodule : epv_props
bind epv_exception_unit epv_props u_props (.*);

// *** verif/testbench.sv ***
// Self-checking bench for the exception unit
`timescale 1ns/1ns
`include "epv_regs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module testbench;
    import epv_pkg::*;
    logic i_clk, i_srst, i_por_req, i_clkmon_fail, i_clock_monitor_enable;
    logic i_forced_clock_monitor_enable, i_wdog_fail, i_trap_req, i_swi_req;
    logic i_nonmaskable_request_pin_n, i_ccr_wr, i_ccr_i, i_ccr_x, o_ccr_i, o_ccr_x;
    logic i_prio_wr, i_ext_req_pin_n, i_external_request_enable, i_edge_only_select;
    logic i_svc_start, o_pending, o_src_ack, o_mem_rd, o_done;
    logic [7:0] i_prio_data, o_prio_sel, i_mem_data;
    logic [`EPV_NSRC-2:0] i_pend, i_en;
    logic [15:0] o_vector, o_mem_addr, o_handler;
    logic [`EPV_IDX_W-1:0] o_src_idx;
    logic [5:0] srcs;
    int n_fail, check_count, cyc;
    // Maskable codes in default order, slot 1 upward
    logic [7:0] tab [18] = '{8'hF0, 8'hEE, 8'hEC, 8'hEA, 8'hE8, 8'hE6, 8'hE4, 8'hE2, 8'hE0,
                             8'hDE, 8'hDC, 8'hDA, 8'hD8, 8'hD6, 8'hD2, 8'hD0, 8'hCC, 8'hCA};
    epv_exception_unit DUT (.*);
    epv_mem_model MEM (.i_clk(i_clk), .i_rd(o_mem_rd), .i_addr(o_mem_addr), .o_data(i_mem_data));
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask : tick
    task automatic svc(input logic [15:0] v);
        int k;
        logic ack;
        @(negedge i_clk) i_svc_start = 1'b1;
        @(negedge i_clk) i_svc_start = 1'b0;
        // Acknowledge stands only in the cycle after the take
        ack = o_src_ack;
        k = 0;
        // Bounded wait so a missing completion cannot hang the run
        while (o_done !== 1'b1 && k < 8) begin
            @(negedge i_clk);
            k++;
        end
        `CHK(o_done, 1'b1)
        `CHK(o_vector, v)
        `CHK(o_handler, {v[7:0] ^ 8'hA5, (v[7:0] + 8'h01) ^ 8'hA5})
        `CHK(ack, v < 16'hFFF4)
    endtask : svc
    task automatic condition_code_reg(input logic i, input logic x);
        @(negedge i_clk) {i_ccr_wr, i_ccr_i, i_ccr_x} = {1'b1, i, x};
        @(negedge i_clk) i_ccr_wr = 1'b0;
        `CHK({o_ccr_i, o_ccr_x}, {i, x})
    endtask : condition_code_reg
    task automatic prio(input logic [7:0] d, input logic [7:0] exp);
        @(negedge i_clk) {i_prio_wr, i_prio_data} = {1'b1, d};
        @(negedge i_clk) i_prio_wr = 1'b0;
        `CHK(o_prio_sel, exp)
    endtask : prio
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        `CHK({o_ccr_i, o_ccr_x}, 2'b11)
        `CHK(o_prio_sel, 8'hF2)
        `CHK(o_pending, 1'b0)
    endtask : t_reset
    task automatic t_nonmask;
        condition_code_reg(1'b1, 1'b0);
        for (int k = 0; k < 6; k++) begin
            srcs = 6'h3F >> k;
            {i_por_req, i_clkmon_fail, i_wdog_fail, i_trap_req, i_swi_req} = srcs[5:1];
            i_nonmaskable_request_pin_n = ~srcs[0];
            tick(4);
            svc(16'hFFFE - 16'(2 * k));
        end
        {i_clkmon_fail, i_clock_monitor_enable} = 2'b10;
        condition_code_reg(1'b1, 1'b1);
        svc(16'hFFF8);
        i_forced_clock_monitor_enable = 1'b1;
        svc(16'hFFFC);
        {i_clkmon_fail, i_nonmaskable_request_pin_n} = 2'b01;
    endtask : t_nonmask
    task automatic t_mask;
        condition_code_reg(1'b0, 1'b1);
        i_pend = '1;
        i_en[0] = 1'b0;
        svc(16'hFFEE);
        `CHK(o_pending, 1'b1)
        i_en[0] = 1'b1;
        for (int s = 0; s < 18; s++) begin
            svc({8'hFF, tab[s]});
            `CHK(o_src_idx, 5'(s + 1))
            i_pend[s] = 1'b0;
        end
    endtask : t_mask
    task automatic t_elev;
        condition_code_reg(1'b1, 1'b1);
        prio(8'hDE, 8'hDE);
        condition_code_reg(1'b0, 1'b1);
        prio(8'hCA, 8'hDE);
        i_pend = 18'h00203;
        svc(16'hFFDE);
        i_en[9] = 1'b0;
        svc(16'hFFF0);
        i_en[9] = 1'b1;
        condition_code_reg(1'b1, 1'b1);
        svc(16'hFFF8);
        `CHK(o_pending, 1'b0)
        i_pend = '0;
    endtask : t_elev
    task automatic t_ext;
        condition_code_reg(1'b0, 1'b1);
        {i_external_request_enable, i_ext_req_pin_n} = 2'b10;
        tick(4);
        svc(16'hFFF2);
        `CHK(o_src_idx, 5'h00)
        {i_edge_only_select, i_ext_req_pin_n} = 2'b11;
        tick(4);
        i_ext_req_pin_n = 1'b0;
        tick(1);
        i_ext_req_pin_n = 1'b1;
        tick(5);
        svc(16'hFFF2);
        svc(16'hFFF8);
    endtask : t_ext
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        {n_fail, check_count, cyc} = '0;
        {i_srst, i_por_req, i_clkmon_fail, i_clock_monitor_enable} = 4'h1;
        {i_forced_clock_monitor_enable, i_wdog_fail, i_trap_req, i_swi_req} = 4'h0;
        {i_nonmaskable_request_pin_n, i_ext_req_pin_n, i_ccr_wr, i_ccr_i, i_ccr_x} = 5'h1B;
        {i_prio_wr, i_prio_data, i_external_request_enable, i_edge_only_select} = '0;
        {i_svc_start, i_pend, i_en} = {1'b0, 18'h00000, 18'h3FFFF};
        i_srst = 1'b1;
        tick(3);
        i_srst = 1'b0;
        t_reset();
        t_nonmask();
        t_mask();
        t_elev();
        t_ext();
        wrap_up();
    end
endmodule : testbench
